// >>> fs_defs.svh
/*
 Constants of the serial control register bank: frame layout, register
 addresses, field positions, reset values and test multiplexer codes.
 Assumes it is included once per compile unit through its guard.
*/
`ifndef FS_DEFS_SVH
`define FS_DEFS_SVH

`define FS_FRAME_BITS   16
`define FS_ADDR_BITS    4
`define FS_DATA_BITS    12
`define FS_CNT_W        5
`define FS_CNT_MAX      5'h1F
`define FS_SHORT_MIN    5'h02
`define FS_SHORT_MAX    5'h0C
`define FS_FULL_LEN     5'h10
`define FS_PIN_IDLE     4'h8

`define FS_ADDR_INT_DIV 4'h0
`define FS_ADDR_FRAC_UP 4'h1
`define FS_ADDR_FRAC_LO 4'h2
`define FS_ADDR_REF_DIV 4'h5
`define FS_ADDR_DET     4'h6
`define FS_ADDR_PWR_MUX 4'h7
`define FS_ADDR_MOD_CTL 4'h8
`define FS_ADDR_MOD_DAT 4'h9

`define FS_RST_INT_DIV  12'h006
`define FS_RST_ZERO     12'h000

`define FS_INT_MSB      8
`define FS_FRAC_UP_MSB  9
`define FS_FRAC_LO_MSB  7
`define FS_REF_MSB      4
`define FS_GAIN_MSB     4
`define FS_STEER_BIT    5
`define FS_FULL_PD_BIT  0
`define FS_SYN_PD_BIT   1
`define FS_MODE_BIT     2
`define FS_FRAC10_BIT   3
`define FS_MUX_LSB      6
`define FS_MUX_MSB      8
`define FS_TRI_BIT      9
`define FS_MAG_MSB      3
`define FS_MOD_SEL_BIT  4
`define FS_ADIS_BIT     5
`define FS_MAG_MAX      4'hD

`define FS_MUX_OSC      3'h0
`define FS_MUX_REF      3'h2
`define FS_MUX_PD       3'h4
`define FS_MUX_SDO      3'h5
`define FS_MUX_STO      3'h6

`endif

// >>> fs_pkg.sv
/*
 Types shared by the serial receiver and the register bank.
 Assumes fs_defs.svh is reachable by its bare name.
*/
`include "fs_defs.svh"

package fs_pkg;
	typedef logic [`FS_DATA_BITS-1:0]  word_t;
	typedef logic [`FS_FRAME_BITS-1:0] frame_t;
	typedef logic [`FS_CNT_W-1:0]      count_t;
	typedef logic signed [24:0]        mod_offset_t;
	typedef enum logic {RX_IDLE, RX_FRAME} rx_state_e;
endpackage : fs_pkg

// >>> serial_frame_rx.sv
/*
 Three-wire serial receiver: resynchronises the pins to the reference
 clock, shifts data and the alternate modulation pin, counts bits and
 hands over a frame when chip select rises.
 Assumes the serial clock is much slower than clk (at least 4 clk per bit).
*/
`timescale 1ns/10ps
`include "fs_defs.svh"

module serial_frame_rx (
	input  logic          clk,
	input  logic          rst,
	input  logic          ser_clk,
	input  logic          ser_data,
	input  logic          mod_in,
	input  logic          cs_n,
	output logic          frame_valid,
	output fs_pkg::count_t frame_bits,
	output fs_pkg::frame_t frame_word,
	output fs_pkg::word_t  mod_word,
	output logic          data_sync
);
	import fs_pkg::*;

	logic [3:0] pin_meta;
	logic [3:0] pin_sync;
	logic       sclk_prev;
	logic       sclk_rise;
	count_t     bit_count;
	frame_t     shift_d;
	word_t      shift_m;
	rx_state_e  state;

	// two stages before any use, pins {cs_n, mod_in, data, clk}
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_meta  <= `FS_PIN_IDLE;
			pin_sync  <= `FS_PIN_IDLE;
			sclk_prev <= 1'b0;
		end else begin
			pin_meta  <= {cs_n, mod_in, ser_data, ser_clk};
			pin_sync  <= pin_meta;
			sclk_prev <= pin_sync[0];
		end
	end

	assign sclk_rise = pin_sync[0] & ~sclk_prev;
	assign data_sync = pin_sync[1];

	always_ff @(posedge clk) begin
		if (rst) begin
			shift_d <= '0;
			shift_m <= '0;
		end else if (sclk_rise && state == RX_FRAME && !pin_sync[3]) begin
			shift_d <= {shift_d[`FS_FRAME_BITS-2:0], pin_sync[1]};
			shift_m <= {shift_m[`FS_DATA_BITS-2:0], pin_sync[2]};
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state       <= RX_IDLE;
			bit_count   <= '0;
			frame_valid <= 1'b0;
			frame_bits  <= '0;
			frame_word  <= '0;
			mod_word    <= '0;
		end else begin
			frame_valid <= 1'b0;
			case (state)
				RX_IDLE: begin
					if (!pin_sync[3]) begin
						state     <= RX_FRAME;
						bit_count <= '0;
					end
				end
				RX_FRAME: begin
					if (pin_sync[3]) begin
						state       <= RX_IDLE;
						frame_valid <= 1'b1;
						frame_bits  <= bit_count;
						frame_word  <= shift_d;
						mod_word    <= shift_m;
					end else if (sclk_rise && bit_count != `FS_CNT_MAX) begin
						bit_count <= bit_count + 5'h01;
					end
				end
				default: state <= RX_IDLE;
			endcase
		end
	end
endmodule : serial_frame_rx

// >>> frac_synth_serial_control.sv
/*
 Write-only control register bank of a fractional-N synthesizer, loaded
 over a three-wire serial port, with the active divide ratio, reference
 divider strobe, modulation pipeline, lock/steer pin and test output.
 Assumes clk is the reference oscillator; detector_compare_freq and the
 serial pins are asynchronous; lock_detect and steer_drive are on clk.
*/
// Function
// - frame is 4 address then 12 data bits
// - reset clears all, divider reads six
// - decode eight addresses, 3 and 4 unused
// - divider holds 9-bit integer minus 32
// - dividend upper 10 bits, lower 8 bits
// - 10-bit modulator ignores lower register
// - reference ratio is index plus one
// - 5-bit detector gain code
// - steer flag picks lock or steering pin
// - full power-down keeps oscillator, serial, mux
// - synth power-down stops synthesizer path only
// - mode flag selects integer-N, stops modulator
// - fractionality flag sizes modulator 18/10
// - mux select bits 8:6 route test output
// - tri-state flag releases test output pin
// - strobe length sets modulation sample width
// - scale sample by two to the m, m capped at 13
// - input-select flag picks modulation pin
// - address-disable flag marks addressless transfers
// - 2 to 12 bit frames are modulation data
// - sample moves on detector falling edges
// - ratio takes effect on upper-register write, integer-N ratio on divider write
// - serial bits resynchronised to reference clock
`timescale 1ns/10ps
`include "fs_defs.svh"

module frac_synth_serial_control (
	input  logic               clk,
	input  logic               rst,
	input  logic               ser_clk,
	input  logic               ser_data,
	input  logic               ser_cs_n,
	input  logic               mod_in,
	input  logic               detector_compare_freq,
	input  logic               lock_detect,
	input  logic               steer_drive,
	output logic [8:0]         active_integer,
	output logic [17:0]        active_dividend,
	output logic               frac_10bit,
	output logic               ref_strobe,
	output logic [4:0]         detector_gain,
	output logic               synth_enable,
	output logic               mod_enable,
	output logic               mod_addr_disable,
	output fs_pkg::mod_offset_t mod_offset,
	output logic               lock_steer_out,
	output logic               lock_steer_oe,
	output logic               test_out,
	output logic               test_out_oe
);
	import fs_pkg::*;

	logic        frame_valid;
	count_t      frame_bits;
	frame_t      frame_word;
	word_t       mod_word;
	logic        data_sync;

	word_t       integer_divider;
	word_t       fraction_upper;
	word_t       fraction_lower;
	word_t       reference_divider;
	word_t       detector_pump_control;
	word_t       power_mux_control;
	word_t       modulation_control;
	word_t       modulation_sample;

	logic [3:0]  frame_addr;
	word_t       frame_data;
	logic        full_frame;
	logic        short_frame;
	word_t       short_raw;
	word_t       short_sample;
	logic [3:0]  ext_shift;
	logic        wr_int;
	logic        wr_upper;
	logic        integer_mode;
	logic        full_pd;
	logic        synth_pd;
	logic        mod_run;
	logic [3:0]  mag_eff;
	logic [4:0]  ref_count;
	logic        osc_half;
	logic        rx_toggle;
	logic [1:0]  pd_meta;
	logic        pd_prev;
	logic        pd_fall;
	word_t       mod_stage;
	mod_offset_t stage_ext;
	logic [2:0]  mux_sel;
	logic [31:0] regs_cat;

	serial_frame_rx u_rx (
		.clk         (clk),
		.rst         (rst),
		.ser_clk     (ser_clk),
		.ser_data    (ser_data),
		.mod_in      (mod_in),
		.cs_n        (ser_cs_n),
		.frame_valid (frame_valid),
		.frame_bits  (frame_bits),
		.frame_word  (frame_word),
		.mod_word    (mod_word),
		.data_sync   (data_sync)
	);

	// address in the top nibble, data below, both arrived msb first
	assign frame_addr  = frame_word[15:12];
	assign frame_data  = frame_word[11:0];
	assign full_frame  = frame_valid && frame_bits == `FS_FULL_LEN;
	assign short_frame = frame_valid && frame_bits >= `FS_SHORT_MIN
		&& frame_bits <= `FS_SHORT_MAX;

	assign integer_mode = power_mux_control[`FS_MODE_BIT];
	assign full_pd      = power_mux_control[`FS_FULL_PD_BIT];
	assign synth_pd     = power_mux_control[`FS_SYN_PD_BIT];
	assign mux_sel      = power_mux_control[`FS_MUX_MSB:`FS_MUX_LSB];

	// short sample sits in the low bits; sign-extend from the strobe length
	assign short_raw = modulation_control[`FS_MOD_SEL_BIT] ? mod_word
		: frame_data;
	assign ext_shift = 4'(5'd12 - frame_bits);
	assign short_sample = word_t'($signed(short_raw << ext_shift)
		>>> ext_shift);

	assign wr_int   = full_frame && frame_addr == `FS_ADDR_INT_DIV;
	assign wr_upper = full_frame && frame_addr == `FS_ADDR_FRAC_UP;

	// unmatched addresses, 3 and 4 among them, fall through untouched
	always_ff @(posedge clk) begin
		if (rst) begin
			integer_divider       <= `FS_RST_INT_DIV;
			fraction_upper        <= `FS_RST_ZERO;
			fraction_lower        <= `FS_RST_ZERO;
			reference_divider     <= `FS_RST_ZERO;
			detector_pump_control <= `FS_RST_ZERO;
			power_mux_control     <= `FS_RST_ZERO;
			modulation_control    <= `FS_RST_ZERO;
		end else if (full_frame) begin
			case (frame_addr)
				`FS_ADDR_INT_DIV: integer_divider       <= frame_data;
				`FS_ADDR_FRAC_UP: fraction_upper        <= frame_data;
				`FS_ADDR_FRAC_LO: fraction_lower        <= frame_data;
				`FS_ADDR_REF_DIV: reference_divider     <= frame_data;
				`FS_ADDR_DET:     detector_pump_control <= frame_data;
				`FS_ADDR_PWR_MUX: power_mux_control     <= frame_data;
				`FS_ADDR_MOD_CTL: modulation_control    <= frame_data;
				default: ;
			endcase
		end
	end

	// short frames are taken whatever the address-disable flag says
	always_ff @(posedge clk) begin
		if (rst) begin
			modulation_sample <= `FS_RST_ZERO;
		end else if (short_frame) begin
			modulation_sample <= short_sample;
		end else if (full_frame && frame_addr == `FS_ADDR_MOD_DAT) begin
			modulation_sample <= frame_data;
		end
	end

	// ratio is double-buffered so a half-written channel never reaches the loop
	always_ff @(posedge clk) begin
		if (rst) begin
			active_integer  <= 9'(`FS_RST_INT_DIV);
			active_dividend <= '0;
		end else if (wr_int && integer_mode) begin
			active_integer <= frame_data[`FS_INT_MSB:0];
		end else if (wr_upper && !integer_mode) begin
			active_integer <= integer_divider[`FS_INT_MSB:0];
			if (frac_10bit) begin
				active_dividend <= {{8{frame_data[`FS_FRAC_UP_MSB]}},
					frame_data[`FS_FRAC_UP_MSB:0]};
			end else begin
				active_dividend <= {frame_data[`FS_FRAC_UP_MSB:0],
					fraction_lower[`FS_FRAC_LO_MSB:0]};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			frac_10bit       <= 1'b0;
			detector_gain    <= '0;
			synth_enable     <= 1'b0;
			mod_enable       <= 1'b0;
			mod_addr_disable <= 1'b0;
		end else begin
			frac_10bit       <= power_mux_control[`FS_FRAC10_BIT];
			detector_gain    <= detector_pump_control[`FS_GAIN_MSB:0];
			synth_enable     <= !full_pd && !synth_pd;
			mod_enable       <= mod_run;
			mod_addr_disable <= modulation_control[`FS_ADIS_BIT];
		end
	end

	assign mod_run = !full_pd && !synth_pd && !integer_mode;

	// index 0 gives a strobe every cycle, i.e. undivided reference
	always_ff @(posedge clk) begin
		if (rst || full_pd) begin
			ref_count  <= '0;
			ref_strobe <= 1'b0;
		end else if (ref_count >= reference_divider[`FS_REF_MSB:0]) begin
			ref_count  <= '0;
			ref_strobe <= 1'b1;
		end else begin
			ref_count  <= ref_count + 5'h01;
			ref_strobe <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pd_meta <= 2'h0;
			pd_prev <= 1'b0;
		end else begin
			pd_meta <= {pd_meta[0], detector_compare_freq};
			pd_prev <= pd_meta[1];
		end
	end

	assign pd_fall = pd_prev & ~pd_meta[1];

	// offsets above 13 would shift a 12-bit sample out of the offset word
	assign mag_eff = (modulation_control[`FS_MAG_MSB:0] > `FS_MAG_MAX)
		? `FS_MAG_MAX : modulation_control[`FS_MAG_MSB:0];
	assign stage_ext = mod_offset_t'($signed(mod_stage));

	// two-stage hand-off: register -> unit -> modulator, one fall each
	always_ff @(posedge clk) begin
		if (rst || !mod_run) begin
			mod_stage  <= '0;
			mod_offset <= '0;
		end else if (pd_fall) begin
			mod_stage  <= modulation_sample;
			mod_offset <= stage_ext <<< mag_eff;
		end
	end

	// lock mode is open collector: low while unlocked, released when locked; steer mode drives steer_drive
	always_ff @(posedge clk) begin
		if (rst || full_pd) begin
			lock_steer_out <= 1'b0;
			lock_steer_oe  <= 1'b0;
		end else if (detector_pump_control[`FS_STEER_BIT]) begin
			lock_steer_out <= steer_drive;
			lock_steer_oe  <= 1'b1;
		end else begin
			lock_steer_out <= 1'b0;
			lock_steer_oe  <= !lock_detect;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			osc_half  <= 1'b0;
			rx_toggle <= 1'b0;
		end else begin
			osc_half <= ~osc_half;
			if (frame_valid) begin
				rx_toggle <= ~rx_toggle;
			end
		end
	end

	// test pin stays alive through full power-down
	always_ff @(posedge clk) begin
		if (rst) begin
			test_out    <= 1'b0;
			test_out_oe <= 1'b0;
		end else begin
			test_out_oe <= !power_mux_control[`FS_TRI_BIT];
			case (mux_sel)
				`FS_MUX_OSC: test_out <= osc_half;
				`FS_MUX_REF: test_out <= ref_strobe;
				`FS_MUX_PD:  test_out <= pd_prev;
				`FS_MUX_SDO: test_out <= data_sync;
				`FS_MUX_STO: test_out <= rx_toggle;
				default:     test_out <= 1'b0;
			endcase
		end
	end

	assign regs_cat = {integer_divider[7:0], fraction_upper[7:0],
		power_mux_control[7:0], modulation_control[7:0]};

	property p_reset_values;
		@(posedge clk) rst |=> integer_divider == `FS_RST_INT_DIV
			&& fraction_upper == `FS_RST_ZERO && modulation_sample == `FS_RST_ZERO;
	endproperty
	a_reset_values: assert property (p_reset_values)
		else $error("reset values wrong");

	property p_unused_addr;
		@(posedge clk) disable iff (rst)
		full_frame && frame_addr == 4'h3 |=> $stable(regs_cat)
			&& $stable(modulation_sample);
	endproperty
	a_unused_addr: assert property (p_unused_addr)
		else $error("unused address changed a register");

	property p_no_frame_no_write;
		@(posedge clk) disable iff (rst)
		!frame_valid |=> $stable(regs_cat) && $stable(modulation_sample);
	endproperty
	a_no_frame_no_write: assert property (p_no_frame_no_write)
		else $error("register changed without a frame");

	property p_short_sample;
		@(posedge clk) disable iff (rst)
		short_frame |=> modulation_sample == $past(short_sample);
	endproperty
	a_short_sample: assert property (p_short_sample)
		else $error("short frame not loaded as sample");

	property p_mod_pipe;
		@(posedge clk) disable iff (rst)
		pd_fall && mod_run ##1 (!pd_fall && mod_run)[*2]
			|-> mod_stage == $past(modulation_sample, 2);
	endproperty
	a_mod_pipe: assert property (p_mod_pipe)
		else $error("sample did not reach the unit on the fall");

	property p_mod_scale;
		@(posedge clk) disable iff (rst)
		pd_fall && mod_run |=> (mod_offset >>> $past(mag_eff))
			== mod_offset_t'($signed($past(mod_stage)));
	endproperty
	a_mod_scale: assert property (p_mod_scale)
		else $error("modulation offset not scaled by 2^m");

	property p_ratio_frac;
		@(posedge clk) disable iff (rst)
		wr_upper && !integer_mode |=> active_integer
			== $past(integer_divider[8:0]);
	endproperty
	a_ratio_frac: assert property (p_ratio_frac)
		else $error("fractional ratio not taken on upper write");

	property p_ratio_hold;
		@(posedge clk) disable iff (rst)
		!integer_mode && !wr_upper |=> $stable(active_integer);
	endproperty
	a_ratio_hold: assert property (p_ratio_hold)
		else $error("ratio changed before upper write");

	property p_tristate;
		@(posedge clk) disable iff (rst)
		power_mux_control[`FS_TRI_BIT] ##1 power_mux_control[`FS_TRI_BIT]
			|-> !test_out_oe;
	endproperty
	a_tristate: assert property (p_tristate)
		else $error("test pin driven while tri-stated");

	property p_lock_pin;
		@(posedge clk) disable iff (rst)
		!detector_pump_control[`FS_STEER_BIT] && !full_pd && !lock_detect
			|=> lock_steer_oe && !lock_steer_out;
	endproperty
	a_lock_pin: assert property (p_lock_pin)
		else $error("lock indicator not pulled low");
endmodule : frac_synth_serial_control

// >>> serial_host.sv
/*
 Host model for the three-wire serial port: shifts frames MSB first,
 full frames and short addressless modulation samples alike.
 Assumes the caller waits for each send to return before the next.
*/
`timescale 1ns/10ps

module serial_host (
	output logic ser_clk,
	output logic ser_data,
	output logic mod_in,
	output logic ser_cs_n
);
	localparam int HALF = 160;

	initial begin
		ser_clk  = 1'b0;
		ser_data = 1'b1;
		mod_in   = 1'b0;
		ser_cs_n = 1'b1;
	end

	// n low bits of word go out; a full frame carries the address in 15:12
	task automatic send(input logic [15:0] word, input int n, input logic alt);
		// odd offset keeps the link phase unrelated to clk
		#37;
		ser_cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			ser_data = alt ? ~ser_data : word[i];
			mod_in   = alt ? word[i] : ~mod_in;
			#HALF ser_clk = 1'b1;
			#HALF ser_clk = 1'b0;
		end
		#HALF ser_cs_n = 1'b1;
		// released lines must not keep showing the last bit
		ser_data = ~ser_data;
		mod_in   = ~mod_in;
		#(3 * HALF);
	endtask : send
endmodule : serial_host

// >>> frac_synth_serial_control_test.sv
/*
 Self-checking bench of the serial control register bank: frames go in
 through the host model, outputs are compared with hand-worked values.
 Assumes the design package and header are compiled first.
*/
`timescale 1ns/10ps

`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
	$display("BAD %s expected %0h seen %0h", nm, exp, got); end end

module frac_synth_serial_control_test;
	import fs_pkg::*;
	logic                clk;
	logic                rst;
	logic                ser_clk;
	logic                ser_data;
	logic                ser_cs_n;
	logic                mod_in;
	logic                detector_compare_freq;
	logic                lock_detect;
	logic                steer_drive;
	logic [8:0]          active_integer;
	logic [17:0]         active_dividend;
	logic                frac_10bit;
	logic                ref_strobe;
	logic [4:0]          detector_gain;
	logic                synth_enable;
	logic                mod_enable;
	logic                mod_addr_disable;
	mod_offset_t         mod_offset;
	logic                lock_steer_out;
	logic                lock_steer_oe;
	logic                test_out;
	logic                test_out_oe;
	int                  fails = 0;
	int                  cmp_count = 0;
	int                  c;
	logic [3:0]          junk_a [7] = '{4'h3, 4'h4, 4'hA, 4'hF, 4'h6, 4'h6, 4'h6};
	int                  junk_n [7] = '{16, 16, 16, 16, 13, 14, 1};
	int                  mux_hi [6] = '{20, 10, 0, 0, 0, 40};
	logic [2:0]          mux_c [6]  = '{3'h0, 3'h2, 3'h1, 3'h3, 3'h7, 3'h4};
	logic [11:0]         mctl [3]   = '{12'h002, 12'h01D, 12'h020};
	int                  mlen [3]   = '{4, 12, 2};
	logic [15:0]         msmp [3]   = '{16'h000B, 16'h0801, 16'h0001};
	mod_offset_t         mexp [3]   = '{-25'sd20, -25'sd16769024, 25'sd1};

	serial_host u_serial_host (
		.ser_clk  (ser_clk),
		.ser_data (ser_data),
		.mod_in   (mod_in),
		.ser_cs_n (ser_cs_n)
	);

	frac_synth_serial_control u_frac_synth_serial_control (
		.clk                   (clk),
		.rst                   (rst),
		.ser_clk               (ser_clk),
		.ser_data              (ser_data),
		.ser_cs_n              (ser_cs_n),
		.mod_in                (mod_in),
		.detector_compare_freq (detector_compare_freq),
		.lock_detect           (lock_detect),
		.steer_drive           (steer_drive),
		.active_integer        (active_integer),
		.active_dividend       (active_dividend),
		.frac_10bit            (frac_10bit),
		.ref_strobe            (ref_strobe),
		.detector_gain         (detector_gain),
		.synth_enable          (synth_enable),
		.mod_enable            (mod_enable),
		.mod_addr_disable      (mod_addr_disable),
		.mod_offset            (mod_offset),
		.lock_steer_out        (lock_steer_out),
		.lock_steer_oe         (lock_steer_oe),
		.test_out              (test_out),
		.test_out_oe           (test_out_oe)
	);

	always #20 clk = ~clk;

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up

	// register update lands within 5 clk of cs rising; 8 leaves margin
	task automatic wr(input logic [3:0] a, input logic [11:0] d);
		u_serial_host.send({a, d}, 16, 1'b0);
		repeat (8) @(negedge clk);
	endtask : wr

	task automatic det_fall;
		detector_compare_freq = 1'b1;
		repeat (8) @(negedge clk);
		detector_compare_freq = 1'b0;
		repeat (8) @(negedge clk);
	endtask : det_fall

	task automatic count40(input logic sel_test, output int n);
		n = 0;
		repeat (40) begin
			@(posedge clk);
			#1 n += int'(sel_test ? test_out : ref_strobe);
		end
		@(negedge clk);
	endtask : count40

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		lock_detect = 1'b0;
		steer_drive = 1'b0;
		detector_compare_freq = 1'b0;
		repeat (12) @(negedge clk);
		`CHK("int_rst", 9'h006, active_integer)
		`CHK("div_rst", 18'h00000, active_dividend)
		`CHK("gain_rst", 5'h00, detector_gain)
		`CHK("mod_rst", mod_offset_t'(0), mod_offset)
		rst = 1'b0;
		repeat (2) @(negedge clk);
		`CHK("tri_rst", 1'b1, test_out_oe)
		$display("test reset done");

		wr(4'h0, 12'h00D);
		`CHK("int_held", 9'h006, active_integer)
		wr(4'h2, 12'h098);
		`CHK("int_held2", 9'h006, active_integer)
		wr(4'h1, 12'h07D);
		`CHK("int_new", 9'h00D, active_integer)
		`CHK("dividend", 18'h07D98, active_dividend)
		$display("test load order done");

		wr(4'h6, 12'h03F);
		steer_drive = 1'b1;
		repeat (2) @(negedge clk);
		`CHK("gain", 5'h1F, detector_gain)
		`CHK("steer_oe", 1'b1, lock_steer_oe)
		`CHK("steer_out", 1'b1, lock_steer_out)
		for (int i = 0; i < 7; i++) begin
			u_serial_host.send({junk_a[i], 12'h000}, junk_n[i], 1'b0);
			repeat (8) @(negedge clk);
		end
		`CHK("gain_kept", 5'h1F, detector_gain)
		`CHK("int_kept", 9'h00D, active_integer)
		wr(4'h6, 12'h005);
		`CHK("gain5", 5'h05, detector_gain)
		`CHK("lock_oe", 1'b1, lock_steer_oe)
		`CHK("lock_out", 1'b0, lock_steer_out)
		lock_detect = 1'b1;
		repeat (2) @(negedge clk);
		`CHK("lock_rel", 1'b0, lock_steer_oe)
		lock_detect = 1'b0;
		$display("test detector done");

		wr(4'h5, 12'h003);
		count40(1'b0, c);
		`CHK("ref_div4", 10, c)
		for (int i = 0; i < 6; i++) begin
			// detector held high so the synced copy shows on the pin
			detector_compare_freq = (i == 5);
			wr(4'h7, {3'h0, mux_c[i], 6'h00});
			count40(1'b1, c);
			`CHK("mux_hi", mux_hi[i], c)
		end
		detector_compare_freq = 1'b0;
		repeat (8) @(negedge clk);
		wr(4'h5, 12'h000);
		count40(1'b0, c);
		`CHK("ref_div1", 40, c)
		$display("test ref and mux done");

		wr(4'h7, 12'h004);
		`CHK("int_mode", 1'b0, mod_enable)
		`CHK("syn_on", 1'b1, synth_enable)
		wr(4'h0, 12'h1FF);
		`CHK("int_now", 9'h1FF, active_integer)
		wr(4'h7, 12'h002);
		`CHK("syn_pd", 1'b0, synth_enable)
		`CHK("syn_pd_tri", 1'b1, test_out_oe)
		wr(4'h7, 12'h001);
		count40(1'b0, c);
		`CHK("full_pd", 1'b0, synth_enable)
		`CHK("full_pd_lock", 1'b0, lock_steer_oe)
		`CHK("full_pd_mux", 1'b1, test_out_oe)
		`CHK("full_pd_ref", 0, c)
		wr(4'h7, 12'h200);
		`CHK("tri_set", 1'b0, test_out_oe)
		`CHK("syn_back", 1'b1, synth_enable)
		$display("test power done");

		wr(4'h7, 12'h008);
		`CHK("frac10", 1'b1, frac_10bit)
		wr(4'h0, 12'h010);
		wr(4'h1, 12'h334);
		`CHK("int10", 9'h010, active_integer)
		`CHK("div10", 18'h3FF34, active_dividend)
		wr(4'h2, 12'h0FF);
		`CHK("div10_lo", 18'h3FF34, active_dividend)
		wr(4'h7, 12'h000);
		`CHK("frac18", 1'b0, frac_10bit)
		`CHK("mod_on", 1'b1, mod_enable)
		$display("test modulator size done");

		for (int i = 0; i < 3; i++) begin
			wr(4'h8, mctl[i]);
			u_serial_host.send(msmp[i], mlen[i], mctl[i][4]);
			repeat (8) @(negedge clk);
			det_fall();
			if (i == 0) begin
				`CHK("mod_early", mod_offset_t'(0), mod_offset)
			end
			det_fall();
			`CHK("mod_out", mexp[i], mod_offset)
		end
		`CHK("addr_dis", 1'b1, mod_addr_disable)
		$display("test modulation done");
		wrap_up();
	end

	// all tests take well under half a millisecond of simulated time
	initial begin
		#2_000_000;
		fails++;
		wrap_up();
	end
endmodule : frac_synth_serial_control_test
